// >>> hdl/key_debounce.sv
/*
 synchroniser and debouncer for active-low panel keys.
 assumes raw key pins asynchronous to pclk; press is a one-cycle pulse.
*/
`timescale 1ns/1ns
module key_debounce #(
    parameter int N = 4,
    parameter int unsigned DEB_CYC = 1000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [N-1:0] key_n,
    key_if.src keys
);
    localparam int CW = $clog2(DEB_CYC + 1);
    genvar i;
    for (i = 0; i < N; i++)
    begin : g_key
        logic s1, s2, stable, pulse;
        logic [CW-1:0] cnt;
        wire raw = ~s2;
        wire differs = raw != stable;
        wire done = cnt == CW'(DEB_CYC - 1);
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                s1 <= 1'b1;
                s2 <= 1'b1;
                cnt <= '0;
                stable <= 1'b0;
                pulse <= 1'b0;
            end
            else
            begin
                s1 <= key_n[i];
                s2 <= s1;
                cnt <= (differs && !done) ? cnt + 1'b1 : '0;
                stable <= (differs && done) ? raw : stable;
                pulse <= differs && done && raw;
            end
        end
        assign keys.held[i] = stable;
        assign keys.press[i] = pulse;
    end
endmodule

// >>> hdl/key_if.sv
/*
 key events between the debouncer and the panel controller.
 assumes one driver per bit, the debouncer.
*/
`timescale 1ns/1ns
interface key_if #(parameter int N = 4);
    logic [N-1:0] held;
    logic [N-1:0] press;
    modport src (output held, output press);
    modport dst (input held, input press);
endinterface

// >>> hdl/panel_pkg.sv
/*
 constants, types and decode functions for the printer front-panel control.
 assumes a 100 MHz pclk and an APB register port with 12-bit byte addresses.
*/
// Overview of operation
// - each select key press while running toggles between off-line and on-line, except off-line during paper-out
// - select lamp lit exactly while on-line
// - go on-line at power-up, select press from off-line, or on-line code
// - go off-line on select press, off-line code, or paper-out
// - top mark key, off-line only, sets current line as page top
// - form feed key, off-line only, feeds to next page top
// - line feed key, off-line only, feeds one line
// - selector positions 0-9 decode to form lengths; lines at 6 or 8 per inch
// - selector sampled at power-up; current paper position becomes page top
// - new length latched on returning on-line after top mark key
// - line feed held at power-up, released after 2 s, enters test mode
// - test mode prints the character pattern then stops by itself
// - jumper picks ready output: always when running, or only on-line
package panel_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned DEBOUNCE_MS = 10;
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int unsigned TEST_HOLD_MS = 2000;
    localparam int unsigned TEST_HOLD_CYC = TEST_HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned SETTLE_CYC = 4;
    localparam logic [7:0] CODE_ON = 8'h11;
    localparam logic [7:0] CODE_OFF = 8'h13;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_PAGE = 12'h008;
    localparam logic [11:0] ADDR_EVENT = 12'h00c;
    localparam int CTRL_LINES_PER_INCH_BIT = 0;
    localparam logic CTRL_LINES_PER_INCH_RST = 1'b0;
    localparam int ST_ONLINE = 0;
    localparam int ST_TEST = 1;
    localparam int ST_STOPPED = 2;
    localparam int ST_PAPER = 3;
    localparam int ST_PENDING = 4;
    localparam int ST_POS_LSB = 8;
    localparam int PG_LINES_LSB = 0;
    localparam int PG_LPOS_LSB = 8;
    localparam int PG_SEL_LSB = 16;
    localparam int EV_SEL = 0;
    localparam int EV_ON = 1;
    localparam int EV_OFF = 2;
    localparam int EV_PAPER = 3;
    localparam int EV_DONE = 4;
    localparam int EV_W = 5;
    localparam logic [3:0] PAGE_POS_RST = 4'h7;
    localparam int KEY_SEL = 0;
    localparam int KEY_TOP = 1;
    localparam int KEY_FF = 2;
    localparam int KEY_LF = 3;
    localparam int N_KEYS = 4;
    localparam logic [7:0] TP_FIRST = 8'h20;
    localparam logic [7:0] TP_LAST = 8'h7e;
    localparam logic [7:0] TP_EOL = 8'h0a;

    typedef enum logic [2:0] {st_boot, st_hold, st_run, st_test, st_stopped} mode_t;

    function automatic logic pos_valid(input logic [3:0] pos);
        return pos <= 4'h9;
    endfunction

    // form length in half inches, times 3 or 4 gives lines
    function automatic logic [6:0] form_lines(input logic [3:0] pos, input logic lines_per_inch);
        logic [8:0] half;
        half = 9'h000;
        case (pos)
            4'h0: half = 9'h006;
            4'h1: half = 9'h007;
            4'h2: half = 9'h008;
            4'h3: half = 9'h00b;
            4'h4: half = 9'h00c;
            4'h5: half = 9'h00e;
            4'h6: half = 9'h010;
            4'h7: half = 9'h016;
            4'h8: half = 9'h018;
            4'h9: half = 9'h01c;
            default: half = 9'h016;
        endcase
        return lines_per_inch ? 7'(half * 9'h004) : 7'(half * 9'h003);
    endfunction
endpackage

// >>> hdl/printer_panel_control.sv
/*
 front-panel control of a line printer: select state, lamp, feed keys,
 page length, power-up test entry and an APB register port.
 assumes presetn release is power-up, host codes arrive as bytes on pclk,
 and the mechanism acts on feed_strobe and the test-pattern stream.
*/
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module printer_panel_control #(
    parameter int unsigned DEB_CYC = panel_pkg::DEBOUNCE_CYC,
    parameter int unsigned TEST_HOLD_CYC = panel_pkg::TEST_HOLD_CYC,
    parameter int TP_COLS = 80,
    parameter int TP_LINES = 96
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic sel_key_n,
    input wire logic page_top_mark_key_n,
    input wire logic form_feed_key_n,
    input wire logic line_feed_key_n,
    input wire logic [3:0] form_pos_pin,
    input wire logic paper_out_pin,
    input wire logic ready_jumper_pin,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic sel_lamp,
    output logic host_ready,
    output logic feed_strobe,
    output logic [6:0] feed_lines,
    output logic tp_valid,
    output logic [7:0] tp_data,
    input wire logic tp_ready,
    output logic test_active
);
    localparam int CW = $clog2(TEST_HOLD_CYC + DEB_CYC + 16);

    // ***********************************
    // pin synchronisers and keys
    // ***********************************
    logic [5:0] pin_s1, pin_s2;
    wire [3:0] form_pos = pin_s2[5:2];
    wire paper_out = pin_s2[1];
    wire jumper = pin_s2[0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1 <= 6'h00;
            pin_s2 <= 6'h00;
        end
        else
        begin
            pin_s1 <= {form_pos_pin, paper_out_pin, ready_jumper_pin};
            pin_s2 <= pin_s1;
        end
    end

    key_if #(.N(panel_pkg::N_KEYS)) keys ();

    key_debounce #(.N(panel_pkg::N_KEYS), .DEB_CYC(DEB_CYC)) u_deb (
        .pclk(pclk),
        .presetn(presetn),
        .key_n({line_feed_key_n, form_feed_key_n, page_top_mark_key_n, sel_key_n}),
        .keys(keys.src)
    );

    // ***********************************
    // mode sequencing
    // ***********************************
    panel_pkg::mode_t mode, next_mode;
    logic [CW-1:0] cnt;
    logic tp_done;
    wire boot_done = cnt == CW'(DEB_CYC + panel_pkg::SETTLE_CYC);
    wire held_long = cnt >= CW'(TEST_HOLD_CYC);
    wire lf_held = keys.held[panel_pkg::KEY_LF];
    wire in_run = mode == panel_pkg::st_run;

    always_comb
    begin
        next_mode = mode;
        case (mode)
            panel_pkg::st_boot:
                if (boot_done)
                    next_mode = lf_held ? panel_pkg::st_hold : panel_pkg::st_run;
            panel_pkg::st_hold:
                if (!lf_held)
                    next_mode = held_long ? panel_pkg::st_test : panel_pkg::st_run;
            panel_pkg::st_test:
                if (tp_done)
                    next_mode = panel_pkg::st_stopped;
            panel_pkg::st_run:
                next_mode = panel_pkg::st_run;
            panel_pkg::st_stopped:
                next_mode = panel_pkg::st_stopped;
            default:
                next_mode = panel_pkg::st_boot;
        endcase
    end

    wire cnt_max = &cnt;
    wire [CW-1:0] next_cnt = (mode != next_mode) ? '0 : (cnt_max ? cnt : cnt + 1'b1);
    wire tp_start = mode == panel_pkg::st_hold && next_mode == panel_pkg::st_test;
    wire boot_exit = (mode == panel_pkg::st_boot || mode == panel_pkg::st_hold)
        && next_mode == panel_pkg::st_run;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode <= panel_pkg::st_boot;
            cnt <= '0;
        end
        else
        begin
            mode <= next_mode;
            cnt <= next_cnt;
        end
    end

    test_pattern #(.COLS(TP_COLS), .LINES(TP_LINES)) u_tp (
        .pclk(pclk),
        .presetn(presetn),
        .start(tp_start),
        .out_ready(tp_ready),
        .out_valid(tp_valid),
        .out_data(tp_data),
        .done(tp_done)
    );

    // ***********************************
    // select state
    // ***********************************
    logic online, pending, paper_q, lines_per_inch;
    logic [3:0] page_pos;
    logic [6:0] line_pos;
    wire sel_press = in_run && keys.press[panel_pkg::KEY_SEL];
    wire code_on = in_run && rx_valid && rx_data == panel_pkg::CODE_ON;
    wire code_off = in_run && rx_valid && rx_data == panel_pkg::CODE_OFF;
    // paper-out and the off-line code beat any request to go on-line except the power-up one at boot_exit
    wire drop = paper_out || code_off || (sel_press && online);
    wire raise = code_on || (sel_press && !online);
    wire next_online = boot_exit ? 1'b1 : (in_run && !drop && (raise || online));
    wire going_online = in_run && !online && next_online;

    // ***********************************
    // page and feed keys
    // ***********************************
    wire offline_run = in_run && !online;
    wire top_act = offline_run && keys.press[panel_pkg::KEY_TOP];
    wire ff_act = offline_run && keys.press[panel_pkg::KEY_FF] && !top_act;
    wire lf_act = offline_run && keys.press[panel_pkg::KEY_LF] && !top_act && !ff_act;
    wire [6:0] page_lines = panel_pkg::form_lines(page_pos, lines_per_inch);
    wire [6:0] to_top = (line_pos < page_lines) ? page_lines - line_pos : page_lines;
    wire [6:0] line_next = (line_pos + 7'h01 >= page_lines) ? 7'h00 : line_pos + 7'h01;
    wire latch_page = going_online && pending && panel_pkg::pos_valid(form_pos);
    wire boot_page = mode == panel_pkg::st_boot && boot_done && panel_pkg::pos_valid(form_pos);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            online <= 1'b0;
            pending <= 1'b0;
            page_pos <= panel_pkg::PAGE_POS_RST;
            line_pos <= 7'h00;
            feed_strobe <= 1'b0;
            feed_lines <= 7'h00;
            paper_q <= 1'b0;
        end
        else
        begin
            online <= next_online;
            paper_q <= paper_out;
            pending <= top_act || (pending && !going_online);
            if (boot_page)
                page_pos <= form_pos;
            else if (latch_page)
                page_pos <= form_pos;
            if (top_act || ff_act || boot_page)
                line_pos <= 7'h00;
            else if (lf_act)
                line_pos <= line_next;
            feed_strobe <= ff_act || lf_act;
            if (ff_act || lf_act)
                feed_lines <= ff_act ? to_top : 7'h01;
        end
    end

    assign sel_lamp = online;
    assign host_ready = jumper ? in_run : online;
    assign test_active = mode == panel_pkg::st_test;

    // ***********************************
    // apb register port
    // ***********************************
    logic [panel_pkg::EV_W-1:0] events;
    logic [31:0] status_word, page_word, ctrl_word, rd_value;
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hit_ctrl = paddr == panel_pkg::ADDR_CTRL;
    wire hit_status = paddr == panel_pkg::ADDR_STATUS;
    wire hit_page = paddr == panel_pkg::ADDR_PAGE;
    wire hit_event = paddr == panel_pkg::ADDR_EVENT;
    wire hit = hit_ctrl || hit_status || hit_page || hit_event;
    wire wr_ctrl = access && pwrite && hit_ctrl;
    wire wr_event = access && pwrite && hit_event;
    wire [panel_pkg::EV_W-1:0] ev_set = {tp_done, paper_out && !paper_q, code_off,
        code_on, sel_press};
    wire [panel_pkg::EV_W-1:0] ev_clr = wr_event ? pwdata[panel_pkg::EV_W-1:0] : '0;

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[panel_pkg::ST_ONLINE] = online;
        status_word[panel_pkg::ST_TEST] = test_active;
        status_word[panel_pkg::ST_STOPPED] = mode == panel_pkg::st_stopped;
        status_word[panel_pkg::ST_PAPER] = paper_out;
        status_word[panel_pkg::ST_PENDING] = pending;
        status_word[panel_pkg::ST_POS_LSB +: 4] = page_pos;
        page_word = 32'h0000_0000;
        page_word[panel_pkg::PG_LINES_LSB +: 7] = page_lines;
        page_word[panel_pkg::PG_LPOS_LSB +: 7] = line_pos;
        page_word[panel_pkg::PG_SEL_LSB +: 4] = form_pos;
        ctrl_word = 32'h0000_0000;
        ctrl_word[panel_pkg::CTRL_LINES_PER_INCH_BIT] = lines_per_inch;
    end

    assign rd_value = hit_ctrl ? ctrl_word :
        hit_status ? status_word :
        hit_page ? page_word :
        hit_event ? {{(32 - panel_pkg::EV_W){1'b0}}, events} : 32'h0000_0000;
    assign pready = 1'b1;
    assign pslverr = access && !hit;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lines_per_inch <= panel_pkg::CTRL_LINES_PER_INCH_RST;
            events <= '0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            if (wr_ctrl)
                lines_per_inch <= pwdata[panel_pkg::CTRL_LINES_PER_INCH_BIT];
            // a new event beats a clear in the same cycle
            events <= (events & ~ev_clr) | ev_set;
            if (setup)
                prdata <= rd_value;
        end
    end

    // ***********************************
    // assertions
    // ***********************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_sel_toggle: assert property (
        (sel_press && !paper_out && !code_on && !code_off) |=> online != $past(online))
        else $error("select press did not toggle");
    a_lamp_offline: assert property (
        !in_run && $past(!in_run) |-> !sel_lamp)
        else $error("lamp lit outside running mode");
    a_code_online: assert property (
        (code_on && !paper_out && !code_off && !sel_press) |=> online && sel_lamp)
        else $error("on-line code ignored");
    a_drop_online: assert property (
        (in_run && (paper_out || code_off)) |=> !online ##1 !online || $past(raise))
        else $error("printer stayed on-line");
    a_feed_offline: assert property (
        $rose(feed_strobe) |-> $past(!online) && $past(in_run))
        else $error("feed while on-line");
    a_form_feed: assert property (
        ff_act |=> feed_strobe && feed_lines == $past(to_top))
        else $error("form feed count wrong");
    a_line_feed: assert property (
        lf_act |=> feed_strobe && feed_lines == 7'h01)
        else $error("line feed count wrong");
    a_top_mark: assert property (
        top_act |=> line_pos == 7'h00 && pending && !feed_strobe)
        else $error("top mark not taken");
    a_page_latch: assert property (
        latch_page |=> page_pos == $past(form_pos) && !pending)
        else $error("page length not latched");
    a_ready_mode: assert property (
        !jumper |-> host_ready == online)
        else $error("ready does not follow select");
    a_test_stop: assert property (
        tp_done |=> mode == panel_pkg::st_stopped ##1 !tp_valid)
        else $error("test mode did not stop");

    c_test_entry: cover property (tp_start);
    c_code_off: cover property (online ##1 code_off ##1 !online);
    c_form_feed: cover property (ff_act ##1 feed_strobe);
    c_new_page: cover property (latch_page);
endmodule

// >>> hdl/test_pattern.sv
/*
 character test-pattern source: rotating printable lines, then done.
 assumes the print path drains it with out_ready.
*/
`timescale 1ns/1ns
module test_pattern #(
    parameter int COLS = 80,
    parameter int LINES = 96
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic out_ready,
    output logic out_valid,
    output logic [7:0] out_data,
    output logic done
);
    logic busy;
    logic [7:0] first;
    logic [$clog2(COLS+1)-1:0] col;
    logic [$clog2(LINES+1)-1:0] line;
    function automatic logic [7:0] nxt(input logic [7:0] c);
        return (c == panel_pkg::TP_LAST) ? panel_pkg::TP_FIRST : c + 8'h01;
    endfunction
    wire step = busy && out_ready;
    wire at_eol = col == ($bits(col))'(COLS);
    wire last_line = line == ($bits(line))'(LINES - 1);
    assign out_valid = busy;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy <= 1'b0;
            done <= 1'b0;
            first <= panel_pkg::TP_FIRST;
            out_data <= panel_pkg::TP_FIRST;
            col <= '0;
            line <= '0;
        end
        else
        begin
            done <= step && at_eol && last_line;
            if (start && !busy)
            begin
                busy <= 1'b1;
                first <= panel_pkg::TP_FIRST;
                out_data <= panel_pkg::TP_FIRST;
                col <= '0;
                line <= '0;
            end
            else if (step && at_eol)
            begin
                busy <= !last_line;
                line <= line + 1'b1;
                col <= '0;
                first <= nxt(first);
                out_data <= nxt(first);
            end
            else if (step)
            begin
                col <= col + 1'b1;
                out_data <= (col == ($bits(col))'(COLS - 1)) ? panel_pkg::TP_EOL : nxt(out_data);
            end
        end
    end
endmodule

// >>> verif/host_model.sv
/*
 host side model: hands one control byte at a time to the receiver.
 assumes the receiver looks at rx_data only while rx_valid is high.
*/
`timescale 1ns/1ns
module host_model (
    input wire logic pclk,
    output logic rx_valid,
    output logic [7:0] rx_data
);
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end
    // called right after an edge: one valid cycle, then idle data inverted
    task automatic send(input logic [7:0] b);
        rx_valid <= 1'b1;
        rx_data <= b;
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_data <= ~b;
        repeat (3) @(posedge pclk);
    endtask
endmodule

// >>> verif/testbench.sv
/*
 self-checking bench for the panel control: keys, host codes, apb, test mode.
 assumes short debounce and hold counts set through the top parameters.
*/
`timescale 1ns/1ns
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
$display("MISMATCH %s expected %0h seen %0h", n, e, a); end end
module testbench;
    localparam int DEB = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] keys_n = 4'hf;
    logic [3:0] form_pos = 4'h3;
    logic paper_out = 1'b0;
    logic jumper = 1'b0;
    logic tp_ready = 1'b0;
    logic pready, pslverr, rx_valid, sel_lamp, host_ready, feed_strobe, tp_valid, test_active;
    logic [31:0] prdata, q;
    logic [7:0] rx_data, tp_data;
    logic [6:0] feed_lines, last_lines;
    logic err;
    int miscompares = 0;
    int total_checks = 0;
    int strobes = 0;
    int s;
    always #5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        if (feed_strobe === 1'b1)
        begin
            strobes++;
            last_lines = feed_lines;
        end
    end
    host_model host (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data));
    printer_panel_control #(.DEB_CYC(DEB), .TEST_HOLD_CYC(50), .TP_COLS(4), .TP_LINES(2)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .sel_key_n(keys_n[0]), .page_top_mark_key_n(keys_n[1]), .form_feed_key_n(keys_n[2]),
        .line_feed_key_n(keys_n[3]), .form_pos_pin(form_pos), .paper_out_pin(paper_out),
        .ready_jumper_pin(jumper), .rx_valid(rx_valid), .rx_data(rx_data),
        .sel_lamp(sel_lamp), .host_ready(host_ready), .feed_strobe(feed_strobe),
        .feed_lines(feed_lines), .tp_valid(tp_valid), .tp_data(tp_data),
        .tp_ready(tp_ready), .test_active(test_active));
    // ****************
    // shared tasks
    // ****************
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 50)
        begin
            miscompares++;
            final_report();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // a press must outlast the debounce, and so must the release
    task automatic press(input int k);
        keys_n <= ~(4'h1 << k);
        cyc(DEB + 12);
        keys_n <= 4'hf;
        cyc(DEB + 12);
    endtask
    task automatic wait_sig(input int which, input logic v);
        int i;
        for (i = 0; i < 300; i++)
        begin
            @(posedge pclk);
            if ((which == 0 ? sel_lamp : test_active) === v)
                break;
        end
        if (i == 300)
        begin
            miscompares++;
            final_report();
        end
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_boot();
        wait_sig(0, 1'b1);
        `CHK("host_ready", 1'b1, host_ready)
        apb(1'b0, 12'h008, 32'h0);
        `CHK("page_lines", 7'd33, q[6:0])
        apb(1'b0, 12'hff0, 32'h0);
        `CHK("unmapped_err", 1'b1, err)
        `CHK("unmapped_data", 32'h0, q)
        $display("test boot done");
    endtask
    task automatic t_select();
        s = strobes;
        press(3);
        press(2);
        `CHK("online_feeds", s, strobes)
        press(0);
        `CHK("lamp_off", 1'b0, sel_lamp)
        `CHK("ready_off", 1'b0, host_ready)
        jumper <= 1'b1;
        cyc(6);
        `CHK("ready_jumper", 1'b1, host_ready)
        jumper <= 1'b0;
        $display("test select done");
    endtask
    task automatic t_feeds();
        s = strobes;
        press(3);
        `CHK("lf_once", s + 1, strobes)
        `CHK("lf_lines", 7'd1, last_lines)
        press(2);
        `CHK("ff_lines", 7'd32, last_lines)
        press(3);
        form_pos <= 4'h9;
        apb(1'b1, 12'h000, 32'h1);
        s = strobes;
        press(1);
        `CHK("top_nofeed", s, strobes)
        apb(1'b0, 12'h008, 32'h0);
        `CHK("top_pos", 7'd0, q[14:8])
        press(0);
        `CHK("lamp_on", 1'b1, sel_lamp)
        apb(1'b0, 12'h008, 32'h0);
        `CHK("new_lines", 7'd112, q[6:0])
        $display("test feeds done");
    endtask
    task automatic t_codes();
        host.send(8'h13);
        `CHK("off_code", 1'b0, sel_lamp)
        host.send(8'h11);
        `CHK("on_code", 1'b1, sel_lamp)
        paper_out <= 1'b1;
        cyc(6);
        `CHK("paper_out", 1'b0, sel_lamp)
        paper_out <= 1'b0;
        cyc(6);
        host.send(8'h11);
        `CHK("on_again", 1'b1, sel_lamp)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK("events", 32'h0000_000f, q)
        apb(1'b1, 12'h00c, 32'h0000_001f);
        apb(1'b0, 12'h00c, 32'h0);
        `CHK("events_clr", 32'h0000_0000, q)
        $display("test codes done");
    endtask
    task automatic t_test();
        int n;
        logic [7:0] first;
        n = 0;
        first = 8'h00;
        presetn <= 1'b0;
        keys_n <= 4'h7;
        cyc(3);
        presetn <= 1'b1;
        cyc(80);
        keys_n <= 4'hf;
        wait_sig(1, 1'b1);
        `CHK("test_lamp", 1'b0, sel_lamp)
        // the far side stalls every other cycle
        for (int i = 0; i < 300 && !(n > 0 && test_active !== 1'b1); i++)
        begin
            @(posedge pclk);
            if (tp_valid === 1'b1 && tp_ready === 1'b1)
            begin
                if (n == 0)
                    first = tp_data;
                n++;
            end
            tp_ready <= ~tp_ready;
        end
        `CHK("tp_count", 10, n)
        `CHK("tp_first", 8'h20, first)
        `CHK("tp_stop", 1'b0, test_active)
        apb(1'b0, 12'h004, 32'h0);
        `CHK("stopped", 5'h04, q[4:0])
        apb(1'b0, 12'h00c, 32'h0);
        `CHK("done_event", 32'h0000_0010, q)
        $display("test pattern done");
    endtask
    initial
    begin
        cyc(20);
        presetn <= 1'b1;
        t_boot();
        t_select();
        t_feeds();
        t_codes();
        t_test();
        final_report();
    end
endmodule
